// ### hw/lsb_alu_pkg.sv
// shared types and constants for the logic, shift and bit datapath
package lsb_alu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned BITNO_W = 3;
  localparam int unsigned CCR_W = 8;
  // condition code register field positions
  localparam int unsigned CCR_C_POS = 0;
  localparam int unsigned CCR_V_POS = 1;
  localparam int unsigned CCR_Z_POS = 2;
  localparam int unsigned CCR_N_POS = 3;
  localparam logic [CCR_W-1:0] CCR_RST = 8'h80;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // sign bit positions per operand size
  localparam int unsigned MSB_B = 7;
  localparam int unsigned MSB_W = 15;
  localparam int unsigned MSB_L = 31;

  typedef enum logic [1:0] {
    SIZE_B,
    SIZE_W,
    SIZE_L
  } op_size_e;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_NOT,
    OP_ARITH_LEFT_SHIFT,
    OP_ARITH_RIGHT_SHIFT,
    OP_LOGIC_LEFT_SHIFT,
    OP_LOGIC_RIGHT_SHIFT,
    OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_BIT_FORCE_ONE,
    OP_BIT_FORCE_ZERO,
    OP_BIT_INVERT,
    OP_BIT_TEST_TO_ZERO_FLAG,
    OP_BIT_AND_CARRY,
    OP_INV_BIT_AND_CARRY,
    OP_BIT_OR_CARRY,
    OP_INV_BIT_OR_CARRY,
    OP_BIT_XOR_CARRY,
    OP_INV_BIT_XOR_CARRY,
    OP_BIT_LOAD_CARRY,
    OP_INV_BIT_LOAD_CARRY,
    OP_CARRY_STORE_BIT,
    OP_INV_CARRY_STORE_BIT
  } op_e;

  // request from the decoder
  typedef struct packed {
    op_e op;
    op_size_e size;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic use_imm;
    logic [DATA_W-1:0] imm;
    logic bit_from_reg;
    logic [BITNO_W-1:0] bit_imm;
    logic to_mem;
  } alu_req_s;

  // answer to the register file
  typedef struct packed {
    logic wr_en;
    op_size_e size;
    logic [DATA_W-1:0] data;
  } alu_rsp_s;

  // memory byte port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_req_s;

endpackage

// ### hw/lsb_bit_unit.sv
// single-bit manipulation unit on one byte operand
`timescale 1ns/100ps
module lsb_bit_unit
  import lsb_alu_pkg::*;
(
  input wire lsb_alu_pkg::op_e op_i,
  input wire logic [7:0] byte_i,
  input wire logic [lsb_alu_pkg::BITNO_W-1:0] bit_no_i,
  input wire logic carry_i,
  output logic [7:0] byte_o,
  output logic carry_o,
  output logic zero_o,
  output logic byte_wr_o,
  output logic carry_wr_o,
  output logic zero_wr_o
);

  logic sel_bit;
  logic [7:0] mask;

  assign sel_bit = byte_i[bit_no_i];
  assign mask = 8'h01 << bit_no_i;

  // one case per operation, defaults leave everything untouched
  always_comb begin
    byte_o = byte_i;
    carry_o = carry_i;
    zero_o = 1'b0;
    byte_wr_o = 1'b0;
    carry_wr_o = 1'b0;
    zero_wr_o = 1'b0;
    case (op_i)
      // [RULE_10] force bit one
      OP_BIT_FORCE_ONE: begin
        byte_o = byte_i | mask;
        byte_wr_o = 1'b1;
      end
      // [RULE_11] force bit zero
      OP_BIT_FORCE_ZERO: begin
        byte_o = byte_i & ~mask;
        byte_wr_o = 1'b1;
      end
      // [RULE_12] toggle selected bit
      OP_BIT_INVERT: begin
        byte_o = byte_i ^ mask;
        byte_wr_o = 1'b1;
      end
      // [RULE_13] zero flag gets complement
      OP_BIT_TEST_TO_ZERO_FLAG: begin
        zero_o = ~sel_bit;
        zero_wr_o = 1'b1;
      end
      // [RULE_15] carry and bit
      OP_BIT_AND_CARRY: begin
        carry_o = carry_i & sel_bit;
        carry_wr_o = 1'b1;
      end
      OP_INV_BIT_AND_CARRY: begin
        carry_o = carry_i & ~sel_bit;
        carry_wr_o = 1'b1;
      end
      // [RULE_16] carry or bit
      OP_BIT_OR_CARRY: begin
        carry_o = carry_i | sel_bit;
        carry_wr_o = 1'b1;
      end
      OP_INV_BIT_OR_CARRY: begin
        carry_o = carry_i | ~sel_bit;
        carry_wr_o = 1'b1;
      end
      // [RULE_17] carry xor bit
      OP_BIT_XOR_CARRY: begin
        carry_o = carry_i ^ sel_bit;
        carry_wr_o = 1'b1;
      end
      OP_INV_BIT_XOR_CARRY: begin
        carry_o = carry_i ^ ~sel_bit;
        carry_wr_o = 1'b1;
      end
      // [RULE_18] bit into carry
      OP_BIT_LOAD_CARRY: begin
        carry_o = sel_bit;
        carry_wr_o = 1'b1;
      end
      OP_INV_BIT_LOAD_CARRY: begin
        carry_o = ~sel_bit;
        carry_wr_o = 1'b1;
      end
      // [RULE_19] carry into bit
      OP_CARRY_STORE_BIT: begin
        byte_o = carry_i ? (byte_i | mask) : (byte_i & ~mask);
        byte_wr_o = 1'b1;
      end
      OP_INV_CARRY_STORE_BIT: begin
        byte_o = carry_i ? (byte_i & ~mask) : (byte_i | mask);
        byte_wr_o = 1'b1;
      end
      default: begin
        byte_o = byte_i;
      end
    endcase
  end

endmodule

// ### hw/logic_shift_bit_alu.sv
// logic, shift, rotate and bit manipulation execution datapath
`timescale 1ns/100ps

// How it works
// [RULE_01] and: destination and source or immediate, result to destination
// [RULE_02] or: destination or source or immediate, result to destination
// [RULE_03] xor: destination xor source or immediate, result to destination
// [RULE_04] not: one's complement of the register within the width
// [RULE_05] logic, shift, rotate work on byte, word or longword widths
// [RULE_06] arithmetic shifts left and right, right keeps the sign
// [RULE_07] logical shifts left and right fill with zero
// [RULE_08] rotate within width, out bit re-enters other end
// [RULE_09] rotate through carry: old carry in, out bit to carry
// [RULE_10] force-one sets the selected byte bit
// [RULE_11] force-zero clears the selected byte bit
// [RULE_12] invert toggles the selected bit and writes byte back
// [RULE_13] bit test puts complement of bit into zero flag
// [RULE_14] bit number from 3-bit immediate or register low three bits
// [RULE_15] carry and bit, inverted form uses complemented bit
// [RULE_16] carry or bit, inverted form uses complemented bit
// [RULE_17] carry xor bit, inverted form uses complemented bit
// [RULE_18] bit load copies bit or its complement into carry
// [RULE_19] carry store writes carry or its complement to bit
// [RULE_20] inverted carry forms take bit number from immediate only
// [RULE_21] carry used is the condition code register carry bit
// [RULE_22] register operands are 8, 16 or 32 bit halves or wholes
// [RULE_23] memory bit ops read byte, modify, write back
module logic_shift_bit_alu
  import lsb_alu_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire lsb_alu_pkg::alu_req_s req_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  input wire logic ccr_load_i,
  input wire logic [lsb_alu_pkg::CCR_W-1:0] ccr_wdata_i,
  output lsb_alu_pkg::alu_rsp_s rsp_o,
  output lsb_alu_pkg::mem_req_s mem_o,
  output logic busy_o,
  output logic done_o,
  output logic [lsb_alu_pkg::CCR_W-1:0] condition_code_register_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM_RD,
    ST_MEM_WR
  } state_e;

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // sign bit of a value at an operand size
  function automatic logic msb_of(input logic [DATA_W-1:0] v,
                                  input op_size_e sz);
    case (sz)
      SIZE_B: msb_of = v[MSB_B];
      SIZE_W: msb_of = v[MSB_W];
      default: msb_of = v[MSB_L];
    endcase
  endfunction

  // clip a value to the operand width, upper bits zero
  function automatic logic [DATA_W-1:0] clip(input logic [DATA_W-1:0] v,
                                             input op_size_e sz);
    case (sz)
      SIZE_B: clip = {24'h00_0000, v[MSB_B:0]};
      SIZE_W: clip = {16'h0000, v[MSB_W:0]};
      default: clip = v;
    endcase
  endfunction

  // place a bit at the top of the operand width
  function automatic logic [DATA_W-1:0] top_bit(input logic b,
                                                input op_size_e sz);
    logic [DATA_W-1:0] r;
    r = DATA_ZERO;
    case (sz)
      SIZE_B: r[MSB_B] = b;
      SIZE_W: r[MSB_W] = b;
      default: r[MSB_L] = b;
    endcase
    top_bit = r;
  endfunction

  // bit operations whose bit number must come from the immediate
  function automatic logic imm_only(input op_e op);
    case (op)
      OP_INV_BIT_AND_CARRY, OP_INV_BIT_OR_CARRY, OP_INV_BIT_XOR_CARRY,
      OP_INV_BIT_LOAD_CARRY, OP_INV_CARRY_STORE_BIT: imm_only = 1'b1;
      default: imm_only = 1'b0;
    endcase
  endfunction

  // all single-bit operations
  function automatic logic is_bit_op(input op_e op);
    is_bit_op = (op >= OP_BIT_FORCE_ONE) && (op <= OP_INV_CARRY_STORE_BIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and signals

  state_e state_q;
  alu_req_s req_q;
  alu_rsp_s rsp_q;
  mem_req_s mem_q;
  logic done_q;
  logic [CCR_W-1:0] ccr_q;

  logic [DATA_W-1:0] opnd_b;
  logic [DATA_W-1:0] a_clip;
  logic [DATA_W-1:0] word_res;
  logic word_carry;
  logic word_wr;
  logic word_carry_wr;
  logic carry_in;
  logic [BITNO_W-1:0] bit_no;
  logic [7:0] bit_byte_in;
  logic [7:0] bit_byte_out;
  logic bit_carry;
  logic bit_zero;
  logic bit_byte_wr;
  logic bit_carry_wr;
  logic bit_zero_wr;
  alu_req_s cur;

  // the operation under way: new request or the held memory one
  assign cur = (state_q == ST_IDLE) ? req_i : req_q;

  ////////////////////////////////////////////////////////////////////////
  // word datapath: logic, shift, rotate

  // [RULE_21] carry taken from the condition code register
  assign carry_in = ccr_q[CCR_C_POS];
  // [RULE_22] operand width picks low byte, low half or whole
  assign a_clip = clip(cur.dst, cur.size);
  assign opnd_b = clip(cur.use_imm ? cur.imm : cur.src, cur.size);

  // one case per operation; results are clipped, upper bits cleared
  always_comb begin
    word_res = a_clip;
    word_carry = carry_in;
    word_wr = 1'b1;
    word_carry_wr = 1'b0;
    case (cur.op)
      // [RULE_01] and with source or immediate
      OP_AND: word_res = a_clip & opnd_b;
      // [RULE_02] or with source or immediate
      OP_OR: word_res = a_clip | opnd_b;
      // [RULE_03] xor with source or immediate
      OP_XOR: word_res = a_clip ^ opnd_b;
      // [RULE_04] one's complement within width
      OP_NOT: word_res = clip(~a_clip, cur.size);
      // [RULE_06] arithmetic left, top bit to carry
      OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: begin
        word_res = clip(a_clip << 1, cur.size);
        word_carry = msb_of(a_clip, cur.size);
        word_carry_wr = 1'b1;
      end
      // [RULE_06] arithmetic right keeps sign
      OP_ARITH_RIGHT_SHIFT: begin
        word_res = (a_clip >> 1) | top_bit(msb_of(a_clip, cur.size),
                                           cur.size);
        word_carry = a_clip[0];
        word_carry_wr = 1'b1;
      end
      // [RULE_07] logical right fills zero
      OP_LOGIC_RIGHT_SHIFT: begin
        word_res = a_clip >> 1;
        word_carry = a_clip[0];
        word_carry_wr = 1'b1;
      end
      // [RULE_08] rotate left within width
      OP_ROTATE_LEFT: begin
        word_res = clip((a_clip << 1) | {31'h0, msb_of(a_clip, cur.size)},
                        cur.size);
        word_carry = msb_of(a_clip, cur.size);
        word_carry_wr = 1'b1;
      end
      // [RULE_08] rotate right within width
      OP_ROTATE_RIGHT: begin
        word_res = (a_clip >> 1) | top_bit(a_clip[0], cur.size);
        word_carry = a_clip[0];
        word_carry_wr = 1'b1;
      end
      // [RULE_09] left through carry
      OP_ROTATE_LEFT_VIA_CARRY: begin
        word_res = clip((a_clip << 1) | {31'h0, carry_in}, cur.size);
        word_carry = msb_of(a_clip, cur.size);
        word_carry_wr = 1'b1;
      end
      // [RULE_09] right through carry
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        word_res = (a_clip >> 1) | top_bit(carry_in, cur.size);
        word_carry = a_clip[0];
        word_carry_wr = 1'b1;
      end
      default: word_wr = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bit datapath

  // [RULE_14] bit number from immediate or register low bits
  // [RULE_20] inverted forms ignore the register selection
  assign bit_no = (cur.bit_from_reg && !imm_only(cur.op)) ?
                  cur.src[BITNO_W-1:0] : cur.bit_imm;
  // memory operand comes from the fetched byte
  assign bit_byte_in = (state_q == ST_MEM_RD) ? mem_rdata_i :
                       cur.dst[MSB_B:0];

  lsb_bit_unit u_bit (
    .op_i(cur.op),
    .byte_i(bit_byte_in),
    .bit_no_i(bit_no),
    .carry_i(carry_in),
    .byte_o(bit_byte_out),
    .carry_o(bit_carry),
    .zero_o(bit_zero),
    .byte_wr_o(bit_byte_wr),
    .carry_wr_o(bit_carry_wr),
    .zero_wr_o(bit_zero_wr)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing

  // [RULE_23] memory bit ops go read, modify, write; carry and test ops end after the read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i && req_i.to_mem && is_bit_op(req_i.op)) begin
            state_q <= ST_MEM_RD;
          end
        end
        ST_MEM_RD: begin
          if (mem_rvalid_i) begin
            state_q <= bit_byte_wr ? ST_MEM_WR : ST_IDLE;
          end
        end
        ST_MEM_WR: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // hold the memory request while the byte is fetched
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      req_q <= '0;
    end else if (state_q == ST_IDLE && req_valid_i) begin
      req_q <= req_i;
    end
  end

  // memory strobes: read on accept, write once modified
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mem_q <= '0;
    end else begin
      mem_q.rd <= (state_q == ST_IDLE) && req_valid_i && req_i.to_mem &&
                  is_bit_op(req_i.op);
      mem_q.wr <= (state_q == ST_MEM_RD) && mem_rvalid_i && bit_byte_wr;
      if (state_q == ST_MEM_RD && mem_rvalid_i) begin
        mem_q.wdata <= bit_byte_out;
      end
    end
  end

  // register writeback, one-cycle pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.wr_en <= 1'b0;
      if (state_q == ST_IDLE && req_valid_i && !req_i.to_mem) begin
        // [RULE_05] result sized to operand width
        if (word_wr) begin
          rsp_q.wr_en <= 1'b1;
          rsp_q.size <= req_i.size;
          rsp_q.data <= word_res;
        end else if (bit_byte_wr) begin
          rsp_q.wr_en <= 1'b1;
          rsp_q.size <= SIZE_B;
          rsp_q.data <= {24'h00_0000, bit_byte_out};
        end
      end
    end
  end

  // completion pulse for every finished operation
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_IDLE && req_valid_i &&
                 !(req_i.to_mem && is_bit_op(req_i.op))) ||
                (state_q == ST_MEM_RD && mem_rvalid_i && !bit_byte_wr) ||
                (state_q == ST_MEM_WR);
    end
  end

  // flags: a decoder load wins, else this op's own flag update
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ccr_q <= CCR_RST;
    end else if (ccr_load_i) begin
      ccr_q <= ccr_wdata_i;
    end else if ((state_q == ST_IDLE && req_valid_i && !req_i.to_mem) ||
                 (state_q == ST_MEM_RD && mem_rvalid_i)) begin
      // [RULE_21] carry lives in the condition code register
      if (word_carry_wr) begin
        ccr_q[CCR_C_POS] <= word_carry;
      end else if (bit_carry_wr) begin
        ccr_q[CCR_C_POS] <= bit_carry;
      end
      // [RULE_13] zero flag from bit test
      if (bit_zero_wr) begin
        ccr_q[CCR_Z_POS] <= bit_zero;
      end
    end
  end

  assign rsp_o = rsp_q;
  assign mem_o = mem_q;
  assign busy_o = (state_q != ST_IDLE);
  assign done_o = done_q;
  assign condition_code_register_o = ccr_q;

endmodule

// ### tb/lsb_alu_chk.sv
// concurrent checks on the ports of the logic, shift and bit datapath
`timescale 1ns/100ps
module lsb_alu_chk
  import lsb_alu_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire lsb_alu_pkg::alu_req_s req_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  input wire logic ccr_load_i,
  input wire logic [lsb_alu_pkg::CCR_W-1:0] ccr_wdata_i,
  input wire lsb_alu_pkg::alu_rsp_s rsp_o,
  input wire lsb_alu_pkg::mem_req_s mem_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [lsb_alu_pkg::CCR_W-1:0] condition_code_register_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic take, reg_take, mod_q, sel;
  ////////////////////////////////////////////////////////////////////////
  // helper terms: accepted request and the addressed register bit
  assign take = req_valid_i && !busy_o;
  assign reg_take = take && !req_i.to_mem && !ccr_load_i;
  assign sel = req_i.dst[req_i.bit_from_reg ? req_i.src[2:0] : req_i.bit_imm];
  // remember whether the running memory op writes its byte back
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mod_q <= 1'b0;
    end else if (take) begin
      mod_q <= req_i.op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO,
        OP_BIT_INVERT, OP_CARRY_STORE_BIT, OP_INV_CARRY_STORE_BIT};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_writeback;
    mem_o.wr ##1 done_o;
  endsequence
  a_reg_done: assert property (take && !req_i.to_mem |=> done_o)
    else $error("register op did not finish in one cycle");
  a_mem_read: assert property (
    take && req_i.to_mem && req_i.op >= OP_BIT_FORCE_ONE |=> mem_o.rd && busy_o)
    else $error("memory bit op did not start a byte read");
  a_mem_wback: assert property (
    busy_o && mem_rvalid_i && mod_q |=> s_writeback)
    else $error("modified byte not written back before done");
  a_mem_nowb: assert property (
    busy_o && mem_rvalid_i && !mod_q |=> !mem_o.wr && done_o)
    else $error("carry only memory op wrote or stalled");
  a_not_data: assert property (
    reg_take && req_i.op == OP_NOT && req_i.size == SIZE_L
    |=> rsp_o.data == ~$past(req_i.dst))
    else $error("longword complement wrong");
  a_test_zero: assert property (
    reg_take && req_i.op == OP_BIT_TEST_TO_ZERO_FLAG
    |=> !rsp_o.wr_en && condition_code_register_o[CCR_Z_POS] == !$past(sel))
    else $error("bit test zero flag wrong");
  a_load_carry: assert property (
    reg_take && req_i.op == OP_BIT_LOAD_CARRY
    |=> condition_code_register_o[CCR_C_POS] == $past(sel))
    else $error("bit load carry wrong");
  a_ccr_load: assert property (
    ccr_load_i |=> condition_code_register_o == $past(ccr_wdata_i))
    else $error("flag register load lost");
  a_rd_pulse: assert property (mem_o.rd |=> !mem_o.rd)
    else $error("byte read longer than one cycle");
endmodule
bind logic_shift_bit_alu lsb_alu_chk chk_u (.clk_sys_i, .rst_b_i, .req_valid_i,
  .req_i, .mem_rdata_i, .mem_rvalid_i, .ccr_load_i, .ccr_wdata_i, .rsp_o,
  .mem_o, .busy_o, .done_o, .condition_code_register_o);

// ### tb/lsb_mem_model.sv
// memory byte responder standing in for the far side of the datapath
`timescale 1ns/100ps
module lsb_mem_model
  import lsb_alu_pkg::*;
(
  input wire logic clk_sys_i,
  input wire lsb_alu_pkg::mem_req_s mem_i,
  input wire logic [7:0] byte_i,
  input wire logic [1:0] lag_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] wbyte_o,
  output logic wseen_o
);
  int cnt = -1;
  initial begin
    rdata_o = 8'h5A;
    rvalid_o = 1'b0;
    wbyte_o = 8'h00;
    wseen_o = 1'b0;
  end
  // answer a read lag_i+1 cycles after it is seen; data wanders outside the answer
  // read then write back
  always @(negedge clk_sys_i) begin
    rvalid_o <= (cnt == 0);
    rdata_o <= (cnt == 0) ? byte_i : ~rdata_o;
    if (mem_i.rd) begin
      cnt <= lag_i;
    end else if (cnt >= 0) begin
      cnt <= cnt - 1;
    end
    wseen_o <= mem_i.wr | (wseen_o & !mem_i.rd);
    if (mem_i.wr) begin
      wbyte_o <= mem_i.wdata;
    end
  end
endmodule

// ### tb/tb.sv
// self-checking bench for the logic, shift and bit datapath
`timescale 1ns/100ps
module tb;
  import lsb_alu_pkg::*;
  logic clk_sys_i, rst_b_i, req_valid_i, ccr_load_i, rvalid, wseen;
  logic busy_o, done_o;
  logic [7:0] ccr_wdata_i, rdata, mbyte, wbyte, ccr_o;
  logic [1:0] lag;
  alu_req_s req_i;
  alu_rsp_s rsp_o;
  mem_req_s mem_o;
  int seed = 18689;
  int n_fail = 0;
  int compares = 0;

  logic_shift_bit_alu dut_u (.clk_sys_i, .rst_b_i, .req_valid_i, .req_i,
    .mem_rdata_i(rdata), .mem_rvalid_i(rvalid), .ccr_load_i, .ccr_wdata_i,
    .rsp_o, .mem_o, .busy_o, .done_o, .condition_code_register_o(ccr_o));
  lsb_mem_model mem_u (.clk_sys_i, .mem_i(mem_o), .byte_i(mbyte),
    .lag_i(lag), .rdata_o(rdata), .rvalid_o(rvalid), .wbyte_o(wbyte),
    .wseen_o(wseen));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %b got %b", what, e, g);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reference: result, write flag, flags and which flags to compare
  function automatic void model(input alu_req_s r, input logic [7:0] mb,
      input logic [7:0] cc, output logic [31:0] d, output logic wr,
      output logic [7:0] f, output logic [1:0] fm);
    int w, n;
    logic [31:0] m, a, b;
    logic [7:0] y;
    logic inv;
    w = (r.size == SIZE_B) ? 8 : (r.size == SIZE_W) ? 16 : 32;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    a = r.dst & m;
    b = (r.use_imm ? r.imm : r.src) & m;
    y = r.to_mem ? mb : r.dst[7:0];
    inv = r.op inside {OP_INV_BIT_AND_CARRY, OP_INV_BIT_OR_CARRY,
      OP_INV_BIT_XOR_CARRY, OP_INV_BIT_LOAD_CARRY, OP_INV_CARRY_STORE_BIT};
    n = (r.bit_from_reg && !inv) ? int'(r.src[2:0]) : int'(r.bit_imm);
    f = cc;
    fm = 2'b00;
    wr = 1'b1;
    d = 32'h0;
    case (r.op)
      OP_AND: d = a & b;
      OP_OR: d = a | b;
      OP_XOR: d = a ^ b;
      OP_NOT: d = ~a & m;
      OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: d = (a << 1) & m;
      OP_ARITH_RIGHT_SHIFT: d = (a >> 1) | (a & (32'h1 << (w - 1)));
      OP_LOGIC_RIGHT_SHIFT: d = a >> 1;
      OP_ROTATE_LEFT: d = ((a << 1) | 32'(a[w-1])) & m;
      OP_ROTATE_RIGHT: d = (a >> 1) | (32'(a[0]) << (w - 1));
      OP_ROTATE_LEFT_VIA_CARRY: d = ((a << 1) | 32'(cc[CCR_C_POS])) & m;
      OP_ROTATE_RIGHT_VIA_CARRY: d = (a >> 1) | (32'(cc[CCR_C_POS]) << (w - 1));
      OP_BIT_FORCE_ONE: y[n] = 1'b1;
      OP_BIT_FORCE_ZERO: y[n] = 1'b0;
      OP_BIT_INVERT: y[n] = ~y[n];
      OP_BIT_TEST_TO_ZERO_FLAG: f[CCR_Z_POS] = ~y[n];
      OP_BIT_AND_CARRY, OP_INV_BIT_AND_CARRY: f[CCR_C_POS] &= y[n] ^ inv;
      OP_BIT_OR_CARRY, OP_INV_BIT_OR_CARRY: f[CCR_C_POS] |= y[n] ^ inv;
      OP_BIT_XOR_CARRY, OP_INV_BIT_XOR_CARRY: f[CCR_C_POS] ^= y[n] ^ inv;
      OP_BIT_LOAD_CARRY, OP_INV_BIT_LOAD_CARRY: f[CCR_C_POS] = y[n] ^ inv;
      default: y[n] = cc[CCR_C_POS] ^ inv;
    endcase
    // shifted-out bit goes to carry: msb on left moves, bit 0 on right
    if (r.op >= OP_ARITH_LEFT_SHIFT && r.op <= OP_ROTATE_RIGHT_VIA_CARRY) begin
      fm = 2'b01;
      f[CCR_C_POS] = (r.op inside {OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT,
        OP_ROTATE_LEFT, OP_ROTATE_LEFT_VIA_CARRY}) ? a[w-1] : a[0];
    end else if (r.op >= OP_BIT_FORCE_ONE) begin
      fm = 2'b11;
      d = {24'h0, y};
      wr = r.op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BIT_INVERT,
        OP_CARRY_STORE_BIT, OP_INV_CARRY_STORE_BIT};
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // preset flags, issue one op, poke it while busy, compare its results
  task automatic run_op(input alu_req_s r);
    logic [31:0] d;
    logic [7:0] cc, f;
    logic [1:0] fm;
    logic wr;
    int k;
    cc = 8'($random(seed));
    @(negedge clk_sys_i);
    chk_bit("done idle", 1'b0, done_o);
    ccr_load_i = 1'b1;
    ccr_wdata_i = cc;
    @(negedge clk_sys_i);
    ccr_load_i = 1'b0;
    req_valid_i = 1'b1;
    req_i = r;
    mbyte = 8'($random(seed));
    lag = 2'($random(seed));
    model(r, mbyte, cc, d, wr, f, fm);
    @(negedge clk_sys_i);
    req_valid_i = r.to_mem;
    k = 0;
    while (done_o !== 1'b1 && k < 20) begin
      @(negedge clk_sys_i);
      k++;
      req_valid_i = r.to_mem && busy_o === 1'b1 && done_o !== 1'b1;
    end
    chk_bit("done", 1'b1, done_o);
    if (r.to_mem) begin
      chk_bit("mem write", wr, wseen);
      if (wr) chk_word("mem byte", d, {24'h0, wbyte});
    end else begin
      chk_bit("reg write", wr, rsp_o.wr_en);
      if (wr) chk_word("reg data", d, rsp_o.data);
    end
    if (fm[0]) chk_bit("carry", f[CCR_C_POS], ccr_o[CCR_C_POS]);
    if (fm[1]) chk_bit("zero", f[CCR_Z_POS], ccr_o[CCR_Z_POS]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // cut a hang short at 20000 cycles, far past the fewer than a thousand expected
  initial begin
    #(40 * 20000);
    n_fail++;
    give_verdict;
  end
  // every op but OP_NONE, logic and shift ops in every size, bit ops on register and memory targets, random operands
  initial begin
    alu_req_s r;
    logic bop;
    rst_b_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    ccr_load_i = 1'b0;
    ccr_wdata_i = 8'h00;
    mbyte = 8'h00;
    lag = 2'h0;
    repeat (5) @(negedge clk_sys_i);
    chk_word("ccr reset", 32'(CCR_RST), 32'(ccr_o));
    chk_bit("busy reset", 1'b0, busy_o);
    rst_b_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      for (int o = int'(OP_AND); o <= int'(OP_INV_CARRY_STORE_BIT); o++) begin
        bop = o >= int'(OP_BIT_FORCE_ONE);
        r.op = op_e'(o);
        r.size = bop ? SIZE_B : op_size_e'(i % 3);
        r.dst = $random(seed);
        r.src = $random(seed);
        r.imm = $random(seed);
        {r.use_imm, r.bit_from_reg, r.bit_imm} = 5'($random(seed));
        r.to_mem = bop && i[0];
        run_op(r);
      end
    end
    give_verdict;
  end
endmodule
